/* inc/flash_cfg_pkg.sv */
// Contract
// (RULE1) Dual bit zero selects dual I/O
// (RULE2) Both bits zero: quad wins over dual
// (RULE3) Dual bit back to one: extended
// (RULE4) Hold bit zero disables hold pin
// (RULE5) Power-on hold comes from non-volatile bit
// (RULE6) Accelerator bit one blocks program voltage
// (RULE7) Accelerated quad modify falls back to extended
// (RULE8) No voltage in 200ms: flag, normal speed
// (RULE9) Driver strength field from non-volatile config
// (RULE10) Flag register layout, eight bits
// (RULE11) Status auto, errors cleared by clear-flag
// (RULE12) Read-flag returns whole flag register
// (RULE13) Ready bit is inverse of write-in-progress
// (RULE14) Erase suspend set on suspend, resume clears
// (RULE15) Host trusts suspend bit only when ready
// (RULE16) Erase error on erase fail or protection
// (RULE17) Erase error sticky; blocks next erase
// (RULE18) Program error on fail, protection, overprogram
// (RULE19) Program error sticky; blocks next program
// (RULE20) Voltage lost during operation sets bit 3
// (RULE21) Host reads errors only once ready
// (RULE22) Quad bit zero selects quad I/O
// (RULE23) Program suspend set on suspend, resume clears
// (RULE24) Protection error sticky until clear-flag
// (RULE25) Reserved flag bit reads zero
package flash_cfg_pkg;
  typedef enum logic [1:0] {
    PROTO_EXT = 2'h0, PROTO_DUAL = 2'h1, PROTO_QUAD = 2'h3
  } proto_t;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'h0, ACC_WAIT = 2'h1, ACC_HIGH = 2'h3
  } acc_state_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0, CMD_WRCFG = 2'h1, CMD_CLRFLAG = 2'h3
  } cmd_t;
  // Instruction codes seen on the link
  localparam logic [7:0] OP_WRITE_CFG = 8'h61;
  localparam logic [7:0] OP_READ_FLAG = 8'h70;
  localparam logic [7:0] OP_CLEAR_FLAG = 8'h50;
  // Link bit counts
  localparam logic [4:0] OPCODE_LAST = 5'h07;
  localparam logic [4:0] DATA_START = 5'h08;
  localparam logic [4:0] WRITE_LAST = 5'h0F;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  // Configuration fields and reset values
  localparam int CFG_QUAD_BIT = 7;
  localparam int CFG_DUAL_BIT = 6;
  localparam int CFG_HOLD_BIT = 4;
  localparam int CFG_ACCEL_BIT = 3;
  localparam logic CFG_QUAD_RST = 1'h1;
  localparam logic CFG_DUAL_RST = 1'h1;
  localparam logic CFG_RSVD_RST = 1'h0;
  localparam logic CFG_ACCEL_RST = 1'h1;
  localparam logic [7:0] CFG_WR_MASK = 8'hDF;
  // Flag register positions
  localparam int FL_READY = 7;
  localparam int FL_ERS_SUSP = 6;
  localparam int FL_ERS_ERR = 5;
  localparam int FL_PGM_ERR = 4;
  localparam int FL_VPP_ERR = 3;
  localparam int FL_PGM_SUSP = 2;
  localparam int FL_PROT_ERR = 1;
  localparam logic FLAG_RST = 1'h0;
  // Program voltage wait
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned VPP_WAIT_MS = 200;
  localparam int unsigned VPP_WAIT_CYC = VPP_WAIT_MS * (CLK_HZ / 1000);
  localparam int VPP_CNT_W = 21;
endpackage : flash_cfg_pkg

/* inc/spi_cmd_if.sv */
`timescale 1ns/100ps
// Commands from the link domain and flag levels back to it
interface spi_cmd_if;
  import flash_cfg_pkg::*;
  logic cmdToggle;
  cmd_t cmdCode;
  logic [7:0] cmdData;
  logic [7:0] flagLevels;
  modport link (output cmdToggle, cmdCode, cmdData, input flagLevels);
  modport core (input cmdToggle, cmdCode, cmdData, output flagLevels);
endinterface : spi_cmd_if

/* design/spi_link_frontend.sv */
`timescale 1ns/100ps
module spi_link_frontend (
  // Link pins
  input logic sclk,
  input logic csN,
  input logic reset_n,
  input logic dq0,
  output logic dq1,
  output logic dq1Oe,
  // Toward the core
  spi_cmd_if.link bus
);
  import flash_cfg_pkg::*;

  logic [4:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] opcode;
  logic [7:0] outReg;
  logic [7:0] flagMeta;
  logic [7:0] flagSync;
  logic [7:0] nextByte;

  assign nextByte = {shiftIn[6:0], dq0};

  // Bit counter and opcode capture, cleared by deselect
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt <= 5'h00;
      opcode <= 8'h00;
      shiftIn <= 8'h00;
    end else begin
      shiftIn <= nextByte;
      if (bitCnt != CNT_MAX) bitCnt <= bitCnt + 5'h01;
      if (bitCnt == OPCODE_LAST) opcode <= nextByte;
    end
  end

  // Completed write-config and clear-flag commands toggle toward the core; data held until next one
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      bus.cmdToggle <= 1'h0;
      bus.cmdCode <= CMD_NONE;
      bus.cmdData <= 8'h00;
    end else if (bitCnt == OPCODE_LAST && nextByte == OP_CLEAR_FLAG) begin
      bus.cmdCode <= CMD_CLRFLAG;
      bus.cmdToggle <= ~bus.cmdToggle;
    end else if (bitCnt == WRITE_LAST && opcode == OP_WRITE_CFG) begin
      bus.cmdCode <= CMD_WRCFG;
      bus.cmdData <= nextByte;
      bus.cmdToggle <= ~bus.cmdToggle;
    end
  end

  // Flag levels brought onto the link clock
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      flagMeta <= 8'h00;
      flagSync <= 8'h00;
    end else begin
      flagMeta <= bus.flagLevels;
      flagSync <= flagMeta;
    end
  end

  // Flag byte shifted out MSB first on falling edges
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      outReg <= 8'h00;
      dq1Oe <= 1'h0;
    end else if (bitCnt == DATA_START && opcode == OP_READ_FLAG) begin
      outReg <= flagSync; // see (RULE12)
      dq1Oe <= 1'h1;
    end else begin
      outReg <= {outReg[6:0], 1'h0};
    end
  end

  assign dq1 = outReg[7];
endmodule : spi_link_frontend

/* design/flash_protocol_config_and_flag_status.sv */
`timescale 1ns/100ps
module flash_protocol_config_and_flag_status #(
  parameter int unsigned VPP_WAIT_CYCLES = flash_cfg_pkg::VPP_WAIT_CYC
) (
  // System
  input logic clk,
  input logic reset_n,
  // Link pins
  input logic sclk,
  input logic csN,
  input logic dq0,
  output logic dq1,
  output logic dq1Oe,
  // Shared pins
  input logic holdPinN,
  input logic vppHigh,
  // Non-volatile configuration, static
  input logic [7:0] nvConfig,
  // Program/erase engine status
  input logic writeInProgress,
  input logic eraseActive,
  input logic programActive,
  input logic opStart,
  input logic eraseFail,
  input logic programFail,
  input logic protectFault,
  input logic overProgram,
  input logic pattern64,
  input logic suspendCmd,
  input logic resumeCmd,
  input logic quadModifyDone,
  // Configuration outputs
  output flash_cfg_pkg::proto_t protocol,
  output logic holdEnable,
  output logic holdActive,
  output logic accelEnable,
  output logic [2:0] driverStrength,
  output logic quadFallback,
  // Acceleration outputs
  output logic accelGranted,
  output logic normalSpeedStart,
  // Flag outputs
  output logic [7:0] flagStatus,
  output logic eraseBlocked,
  output logic programBlocked
);
  import flash_cfg_pkg::*;

  localparam logic [VPP_CNT_W-1:0] VPP_LAST =
    VPP_CNT_W'(VPP_WAIT_CYCLES - 1);

  // Protocol chosen by the two command bits
  function automatic proto_t decode_proto(input logic quadN,
                                          input logic dualN);
    proto_t p;
    p = PROTO_EXT;
    if (!quadN) p = PROTO_QUAD; // see (RULE2) see (RULE22)
    else if (!dualN) p = PROTO_DUAL; // see (RULE1)
    return p;
  endfunction : decode_proto

  // Sticky error bit: set wins over clear
  function automatic logic sticky(input logic old, input logic set,
                                  input logic clr);
    return set | (old & ~clr);
  endfunction : sticky

  spi_cmd_if cmdBus ();

  // Link-clock logic
  spi_link_frontend linkEnd (
    .sclk(sclk),
    .csN(csN),
    .reset_n(reset_n),
    .dq0(dq0),
    .dq1(dq1),
    .dq1Oe(dq1Oe),
    .bus(cmdBus.link)
  );

  logic togMeta;
  logic togSync;
  logic togSeen;
  logic cmdStrobe;
  logic writeCfg;
  logic clearFlags;
  logic holdMeta;
  logic holdSync;
  logic vppMeta;
  logic vppSync;
  logic vppSyncD;
  logic vppFall;
  logic [7:0] cfg;
  acc_state_t accState;
  logic [VPP_CNT_W-1:0] vppTimer;
  logic vppTimeout;
  logic vppAtStart;
  logic vppDrop;
  logic readyBit;
  logic ersSusp;
  logic pgmSusp;
  logic ersErr;
  logic pgmErr;
  logic vppErr;
  logic protErr;
  logic ersErrSet;
  logic pgmErrSet;
  logic vppErrSet;
  logic quadModAccel;

  // Command toggle crossing into the core clock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      togMeta <= 1'h0;
      togSync <= 1'h0;
      togSeen <= 1'h0;
    end else begin
      togMeta <= cmdBus.cmdToggle;
      togSync <= togMeta;
      togSeen <= togSync;
    end
  end

  // One pulse per completed write-config or clear-flag instruction; data is stable by now
  assign cmdStrobe = togSync ^ togSeen;
  assign writeCfg = cmdStrobe && (cmdBus.cmdCode == CMD_WRCFG);
  assign clearFlags = cmdStrobe && (cmdBus.cmdCode == CMD_CLRFLAG);

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      holdMeta <= 1'h1;
      holdSync <= 1'h1;
      vppMeta <= 1'h0;
      vppSync <= 1'h0;
      vppSyncD <= 1'h0;
    end else begin
      holdMeta <= holdPinN;
      holdSync <= holdMeta;
      vppMeta <= vppHigh;
      vppSync <= vppMeta;
      vppSyncD <= vppSync;
    end
  end

  assign vppFall = vppSyncD & ~vppSync;

  // Enhanced configuration: power-on values, then instruction writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg <= {CFG_QUAD_RST, CFG_DUAL_RST, CFG_RSVD_RST,
              nvConfig[CFG_HOLD_BIT], // see (RULE5)
              CFG_ACCEL_RST, // see (RULE6)
              nvConfig[2:0]}; // see (RULE9)
    end else if (writeCfg) begin
      cfg <= cmdBus.cmdData & CFG_WR_MASK; // see (RULE4)
    end
  end

  // Configuration fields as seen by the rest of the chip
  assign holdEnable = cfg[CFG_HOLD_BIT]; // see (RULE4)
  assign accelEnable = ~cfg[CFG_ACCEL_BIT]; // see (RULE6)
  assign driverStrength = cfg[2:0]; // see (RULE9)

  // Hold only acts while the function is enabled
  always_ff @(posedge clk) begin
    if (!reset_n) holdActive <= 1'h0;
    else holdActive <= holdEnable & ~holdSync; // see (RULE4)
  end

  // Active protocol; fallback forces extended
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      protocol <= PROTO_EXT;
    end else if (quadFallback) begin
      protocol <= PROTO_EXT; // see (RULE7)
    end else begin
      // see (RULE1) see (RULE3)
      protocol <= decode_proto(cfg[CFG_QUAD_BIT], cfg[CFG_DUAL_BIT]);
    end
  end

  // Quad modify with acceleration allowed
  assign quadModAccel = quadModifyDone & accelEnable; // see (RULE6)

  // Temporary extended fallback until the voltage returns to normal
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      quadFallback <= 1'h0;
    end else if (quadModAccel &&
                 decode_proto(cfg[CFG_QUAD_BIT], cfg[CFG_DUAL_BIT]) ==
                 PROTO_QUAD) begin
      quadFallback <= 1'h1; // see (RULE7)
    end else if (vppFall) begin
      quadFallback <= 1'h0; // see (RULE7)
    end
  end

  // Wait for the program voltage after a quad modify
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accState <= ACC_IDLE;
    end else begin
      unique case (accState)
        ACC_IDLE: begin
          if (quadModAccel) accState <= ACC_WAIT;
        end
        ACC_WAIT: begin
          if (vppSync) accState <= ACC_HIGH;
          else if (vppTimer == VPP_LAST) accState <= ACC_IDLE; // see (RULE8)
        end
        ACC_HIGH: begin
          if (!vppSync) accState <= ACC_IDLE;
        end
        default: begin
          accState <= ACC_IDLE;
        end
      endcase
    end
  end

  // Wait timer, runs only while waiting
  always_ff @(posedge clk) begin
    if (!reset_n) vppTimer <= '0;
    else if (accState == ACC_WAIT) vppTimer <= vppTimer + VPP_CNT_W'(1);
    else vppTimer <= '0;
  end

  assign vppTimeout = (accState == ACC_WAIT) && !vppSync &&
                      (vppTimer == VPP_LAST);
  assign accelGranted = (accState == ACC_HIGH);

  // Pulse telling the engine to start at normal speed
  always_ff @(posedge clk) begin
    if (!reset_n) normalSpeedStart <= 1'h0;
    else normalSpeedStart <= vppTimeout; // see (RULE8)
  end

  // Program voltage sampled at operation start
  always_ff @(posedge clk) begin
    if (!reset_n) vppAtStart <= 1'h0;
    else if (opStart) vppAtStart <= vppSync; // see (RULE20)
    else if (!writeInProgress) vppAtStart <= 1'h0;
  end

  // Voltage lost while a started operation still runs
  assign vppDrop = writeInProgress & vppAtStart & ~vppSync;

  // Error set terms
  assign ersErrSet = eraseFail | (protectFault & eraseActive); // see (RULE16)
  assign pgmErrSet = programFail | (protectFault & programActive) |
                     (overProgram & vppSync & pattern64); // see (RULE18)
  assign vppErrSet = vppTimeout | vppDrop; // see (RULE8) see (RULE20)

  // Ready bit follows the engine
  always_ff @(posedge clk) begin
    if (!reset_n) readyBit <= 1'h1;
    else readyBit <= ~writeInProgress; // see (RULE13)
  end

  // Suspend status bits, set wins over resume
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ersSusp <= FLAG_RST;
      pgmSusp <= FLAG_RST;
    end else begin
      if (suspendCmd && eraseActive) ersSusp <= 1'h1; // see (RULE14)
      else if (resumeCmd) ersSusp <= 1'h0; // see (RULE14)
      if (suspendCmd && programActive) pgmSusp <= 1'h1; // see (RULE23)
      else if (resumeCmd) pgmSusp <= 1'h0; // see (RULE23)
    end
  end

  // Error bits cleared only by the clear-flag instruction
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ersErr <= FLAG_RST;
      pgmErr <= FLAG_RST;
      vppErr <= FLAG_RST;
      protErr <= FLAG_RST;
    end else begin
      ersErr <= sticky(ersErr, ersErrSet, clearFlags); // see (RULE17)
      pgmErr <= sticky(pgmErr, pgmErrSet, clearFlags); // see (RULE19)
      vppErr <= sticky(vppErr, vppErrSet, clearFlags); // see (RULE11)
      protErr <= sticky(protErr, protectFault, clearFlags); // see (RULE24)
    end
  end

  // Flag register image; reserved bit reads zero
  assign flagStatus = {readyBit, ersSusp, ersErr, pgmErr,
                       vppErr, pgmSusp, protErr,
                       1'h0}; // see (RULE10) see (RULE25)
  assign cmdBus.flagLevels = flagStatus; // see (RULE12)

  // Pending erase or program error, or a voltage error, makes the next modify of that kind appear to fail
  assign eraseBlocked = ersErr | vppErr; // see (RULE17)
  assign programBlocked = pgmErr | vppErr; // see (RULE19)

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Steps of an accelerated quad modify
  sequence seq_quad_mod;
    quadModAccel && (accState == ACC_IDLE) && !vppFall &&
    (decode_proto(cfg[CFG_QUAD_BIT], cfg[CFG_DUAL_BIT]) == PROTO_QUAD);
  endsequence

  sequence seq_fallback_on;
    quadFallback && (protocol == PROTO_EXT);
  endsequence

  sequence seq_timeout;
    (accState == ACC_WAIT) && !vppSync && (vppTimer == VPP_LAST);
  endsequence

  a_quad_priority: assert property ( // see (RULE2)
    !cfg[CFG_QUAD_BIT] && !quadFallback |=> protocol == PROTO_QUAD)
    else $error("quad bit clear but protocol not quad");

  a_dual_select: assert property ( // see (RULE1)
    cfg[CFG_QUAD_BIT] && !cfg[CFG_DUAL_BIT] && !quadFallback
    |=> protocol == PROTO_DUAL)
    else $error("dual bit clear but protocol not dual");

  a_ext_return: assert property ( // see (RULE3)
    cfg[CFG_QUAD_BIT] && cfg[CFG_DUAL_BIT] |=> protocol == PROTO_EXT)
    else $error("both bits set but protocol not extended");

  a_cfg_write: assert property ( // see (RULE4)
    writeCfg |=> cfg == ($past(cmdBus.cmdData) & CFG_WR_MASK))
    else $error("configuration write not taken");

  a_hold_gate: assert property ( // see (RULE4)
    !holdEnable |=> !holdActive)
    else $error("hold acted while disabled");

  a_fallback_seq: assert property ( // see (RULE7)
    seq_quad_mod |=> quadFallback ##1 seq_fallback_on)
    else $error("no extended fallback after quad modify");

  a_vpp_timeout: assert property ( // see (RULE8)
    seq_timeout |=> vppErr && normalSpeedStart ##1 accState == ACC_IDLE)
    else $error("voltage timeout not flagged");

  a_ready_inverse: assert property ( // see (RULE13)
    ##1 readyBit == !$past(writeInProgress))
    else $error("ready bit not inverse of busy");

  a_erase_susp: assert property ( // see (RULE14)
    suspendCmd && eraseActive |=> ersSusp)
    else $error("erase suspend bit not set");

  a_erase_sticky: assert property ( // see (RULE17)
    ersErr && !clearFlags |=> ersErr)
    else $error("erase error dropped without clear");

  a_err_clear: assert property ( // see (RULE11)
    clearFlags && !pgmErrSet && !protectFault |=> !pgmErr && !protErr)
    else $error("clear-flag did not clear errors");

  a_rsvd_zero: assert property ( // see (RULE25)
    flagStatus[0] == 1'h0 && cmdBus.flagLevels == flagStatus)
    else $error("reserved flag bit not zero");
endmodule : flash_protocol_config_and_flag_status

/* testbench/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
  // Link pins
  output logic sclk,
  output logic csN,
  output logic dq0,
  // Answer from the device
  input wire logic dq1,
  input wire logic dq1Oe
);
  // Idle link: clock parked low, device deselected
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    dq0 = 1'b0;
  end

  // Mode 0 frame, MSB first, 15 ns link period; clock runs only in frames
  task automatic xfer(input logic [15:0] bits, input int nbits,
                      input int lagNs, output logic [7:0] rd);
    rd = 8'h00;
    #(lagNs);
    #3.3 csN = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      dq0 = bits[15 - i];
      #7.5 sclk = 1'b1;
      // Undriven answer reads as unknown
      if (i >= 8) rd = {rd[6:0], dq1Oe ? dq1 : 1'bx};
      #7.5 sclk = 1'b0;
    end
    #7.5 csN = 1'b1;
    // Released data line shows the inverse of its last bit
    dq0 = ~dq0;
  endtask : xfer
endmodule : spi_host_model

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import flash_cfg_pkg::*;
  localparam int WAIT_CYC = 20;
  logic clk;
  logic reset_n;
  logic holdPinN;
  logic vppHigh;
  logic writeInProgress;
  logic eraseActive;
  logic programActive;
  logic pattern64;
  logic [7:0] nvConfig;
  logic [7:0] pls;
  logic sclk, csN, dq0, dq1, dq1Oe;
  proto_t protocol;
  logic holdEnable, holdActive, accelEnable, quadFallback;
  logic accelGranted, normalSpeedStart, eraseBlocked, programBlocked;
  logic [2:0] driverStrength;
  logic [7:0] flagStatus;
  logic [7:0] rd;
  logic [7:0] dutView;
  int numErrors = 0;
  int checkCount = 0;

  // Configuration outputs packed for comparison
  assign dutView = {protocol, holdEnable, holdActive, accelEnable,
                    driverStrength};

  flash_protocol_config_and_flag_status #(
    .VPP_WAIT_CYCLES(WAIT_CYC)
  ) u_flash_protocol_config_and_flag_status (
    .clk(clk), .reset_n(reset_n), .sclk(sclk), .csN(csN), .dq0(dq0),
    .dq1(dq1), .dq1Oe(dq1Oe), .holdPinN(holdPinN), .vppHigh(vppHigh),
    .nvConfig(nvConfig), .writeInProgress(writeInProgress),
    .eraseActive(eraseActive), .programActive(programActive),
    .opStart(pls[0]), .eraseFail(pls[1]), .programFail(pls[2]),
    .protectFault(pls[3]), .overProgram(pls[4]), .pattern64(pattern64),
    .suspendCmd(pls[5]), .resumeCmd(pls[6]), .quadModifyDone(pls[7]),
    .protocol(protocol), .holdEnable(holdEnable), .holdActive(holdActive),
    .accelEnable(accelEnable), .driverStrength(driverStrength),
    .quadFallback(quadFallback), .accelGranted(accelGranted),
    .normalSpeedStart(normalSpeedStart), .flagStatus(flagStatus),
    .eraseBlocked(eraseBlocked), .programBlocked(programBlocked)
  );

  spi_host_model u_spi_host_model (
    .sclk(sclk), .csN(csN), .dq0(dq0), .dq1(dq1), .dq1Oe(dq1Oe)
  );

  // Core clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask : clks

  // One-cycle engine pulse, then one cycle for the flag to land
  task automatic pulse(input int b);
    @(negedge clk);
    pls[b] = 1'b1;
    @(negedge clk);
    pls = 8'h00;
    @(negedge clk);
  endtask : pulse

  // Expected configuration view worked out from a written byte
  function automatic logic [7:0] cfgView(input logic [7:0] c);
    proto_t p;
    p = !c[7] ? PROTO_QUAD : !c[6] ? PROTO_DUAL : PROTO_EXT;
    return {p, c[4], c[4] & ~holdPinN, ~c[3], c[2:0]};
  endfunction : cfgView

  // Link frame, then time for the crossing to settle
  task automatic link(input logic [7:0] op, input logic [7:0] d,
                      input int n);
    u_spi_host_model.xfer({op, d}, n, (op == OP_READ_FLAG) ? 40 : 0, rd);
    clks(8);
  endtask : link

  task automatic doReset(input logic [7:0] nv);
    @(negedge clk);
    reset_n = 1'b0;
    nvConfig = nv;
    clks(2);
    reset_n = 1'b1;
    clks(2);
    check(dutView, {PROTO_EXT, nv[4], 2'h0, nv[2:0]});
    check(flagStatus, 8'h80);
  endtask : doReset

  task automatic testCfg();
    logic [7:0] vals [6] = '{8'hDF, 8'h9F, 8'h5F, 8'h1F, 8'hDF, 8'hC2};
    holdPinN = 1'b0;
    foreach (vals[i]) begin
      link(OP_WRITE_CFG, vals[i], 16);
      check(dutView, cfgView(vals[i]));
    end
    // Cut-short frame must leave the configuration alone
    link(OP_WRITE_CFG, 8'h1F, 9);
    check(dutView, cfgView(8'hC2));
    holdPinN = 1'b1;
  endtask : testCfg

  task automatic testErrors();
    logic [7:0] expv [4] = '{8'hA0, 8'h90, 8'h82, 8'h90};
    pattern64 = 1'b1;
    vppHigh = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pulse(i + 1);
      clks(3);
      check(flagStatus, expv[i]);
      check({6'h0, eraseBlocked, programBlocked},
            {6'h0, expv[i][5], expv[i][4]});
      link(OP_CLEAR_FLAG, 8'h00, 8);
      check(flagStatus, 8'h80);
    end
    vppHigh = 1'b0;
  endtask : testErrors

  task automatic testStatus();
    writeInProgress = 1'b1;
    eraseActive = 1'b1;
    clks(3);
    check(flagStatus, 8'h00);
    pulse(5);
    check(flagStatus, 8'h40);
    // Suspend bit is only trusted once the engine reports ready
    writeInProgress = 1'b0;
    clks(3);
    link(OP_READ_FLAG, 8'h00, 16);
    check(rd, 8'hC0);
    writeInProgress = 1'b1;
    clks(3);
    pulse(6);
    check(flagStatus, 8'h00);
    eraseActive = 1'b0;
    programActive = 1'b1;
    pulse(5);
    check(flagStatus, 8'h04);
    pulse(6);
    // Voltage high at operation start, then lost mid-operation
    vppHigh = 1'b1;
    clks(3);
    pulse(0);
    vppHigh = 1'b0;
    clks(4);
    check(flagStatus, 8'h08);
    programActive = 1'b0;
    writeInProgress = 1'b0;
    clks(3);
    // Host reads errors only once ready
    link(OP_READ_FLAG, 8'h00, 16);
    check(rd, 8'h88);
    link(OP_CLEAR_FLAG, 8'h00, 8);
  endtask : testStatus

  task automatic testAccel();
    int n;
    link(OP_WRITE_CFG, 8'h17, 16);
    pulse(7);
    check({5'h0, quadFallback, protocol},
          {5'h0, 1'h1, PROTO_EXT});
    vppHigh = 1'b1;
    clks(4);
    check({7'h0, accelGranted}, 8'h01);
    vppHigh = 1'b0;
    clks(5);
    check({5'h0, quadFallback, protocol},
          {5'h0, 1'h0, PROTO_QUAD});
    // No voltage raised: timeout pulse and voltage error
    n = 0;
    pulse(7);
    repeat (WAIT_CYC + 10) begin
      @(negedge clk);
      if (normalSpeedStart === 1'b1) n++;
    end
    check(n[7:0], 8'h01);
    check(flagStatus, 8'h88);
    vppHigh = 1'b1;
    clks(4);
    vppHigh = 1'b0;
    clks(5);
    link(OP_CLEAR_FLAG, 8'h00, 8);
    check(flagStatus, 8'h80);
  endtask : testAccel

  task automatic final_report();
    $display("checks=%0d errors=%0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Watchdog far beyond the expected run length
  initial begin
    #2_000_000;
    numErrors++;
    final_report();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    holdPinN = 1'b1;
    vppHigh = 1'b0;
    writeInProgress = 1'b0;
    eraseActive = 1'b0;
    programActive = 1'b0;
    pattern64 = 1'b0;
    nvConfig = 8'h15;
    pls = 8'h00;
    doReset(8'h15);
    testCfg();
    testErrors();
    testStatus();
    testAccel();
    doReset(8'h02);
    final_report();
  end
endmodule : testbench
